// ==== core/rtdenc_pkg.sv ====
// Package: constants and types of the thermometer value range encoder
package rtdenc_pkg;

	// ==========================================
	// Register map (byte addresses)
	localparam logic [4:0] ADDR_CTRL = 5'h00;
	localparam logic [4:0] ADDR_STATUS = 5'h04;
	localparam logic [4:0] ADDR_MASK = 5'h08;
	localparam logic [4:0] ADDR_RESULT = 5'h0c;
	localparam logic [4:0] ADDR_DIAG = 5'h10;

	// ==========================================
	// Field positions
	localparam int CTRL_SENSOR_LSB = 0;
	localparam int CTRL_UNIT_LSB = 2;
	localparam int CTRL_WB_EN_BIT = 4;
	localparam int CTRL_OVF_EN_BIT = 5;
	localparam int EV_WIRE_BIT = 0;
	localparam int EV_LOW_BIT = 1;
	localparam int EV_HIGH_BIT = 2;
	localparam int RESULT_BAND_LSB = 16;
	localparam int DIAG_COUNT_LSB = 8;

	// ==========================================
	// Types
	typedef enum logic [1:0] {SENS_PT_CLIMATE, SENS_NI_STANDARD, SENS_NI_CLIMATE} rtdenc_sensor_e;
	typedef enum logic [1:0] {UNIT_CELSIUS, UNIT_FAHRENHEIT, UNIT_KELVIN} rtdenc_unit_e;
	typedef enum logic [2:0] {BAND_NOMINAL, BAND_OVERRANGE, BAND_UNDERRANGE, BAND_OVERFLOW,
		BAND_UNDERFLOW} rtdenc_band_e;

	typedef struct packed {
		logic ovf_en;
		logic wb_en;
		rtdenc_unit_e unit;
		rtdenc_sensor_e sensor;
	} rtdenc_ctrl_s;

	typedef struct packed {
		logic signed [31:0] over_hi;
		logic signed [31:0] nom_hi;
		logic signed [31:0] nom_lo;
		logic signed [31:0] under_lo;
	} rtdenc_lim_s;

	// ==========================================
	// Reset values
	localparam rtdenc_ctrl_s CTRL_RESET = '{1'b0, 1'b0, UNIT_CELSIUS, SENS_PT_CLIMATE};
	localparam logic [2:0] EV_RESET = 3'h0;
	localparam logic [7:0] COUNT_RESET = 8'h00;

	// ==========================================
	// Result codes and scaling constants
	localparam logic [15:0] CODE_OVERFLOW = 16'h7fff;
	localparam logic [15:0] CODE_UNDERFLOW = 16'h8000;
	localparam logic signed [31:0] F_OFFSET = 32'sd3200;
	localparam logic signed [31:0] K_OFFSET = 32'sd27315;

	// ==========================================
	// Band limits, inclusive, in output counts
	localparam rtdenc_lim_s LIM_PT_C = '{32'sd15500, 32'sd13000, -32'sd12000, -32'sd14500};
	localparam rtdenc_lim_s LIM_PT_F = '{32'sd31100, 32'sd26600, -32'sd18400, -32'sd22900};
	localparam rtdenc_lim_s LIM_NS_C = '{32'sd2950, 32'sd2500, -32'sd600, -32'sd1050};
	localparam rtdenc_lim_s LIM_NS_F = '{32'sd5630, 32'sd4820, -32'sd760, -32'sd1570};
	localparam rtdenc_lim_s LIM_NS_K = '{32'sd5682, 32'sd5232, 32'sd2132, 32'sd1682};
	localparam rtdenc_lim_s LIM_NC_C = '{32'sd15500, 32'sd13000, -32'sd6000, -32'sd10500};
	localparam rtdenc_lim_s LIM_NC_F = '{32'sd31100, 32'sd26600, -32'sd7600, -32'sd15700};

endpackage : rtdenc_pkg

// ==== core/rtdenc_top.sv ====
// Module: thermometer value range encoder with Avalon-MM registers
//
// Notes on behaviour
// - Pt 100 Climate: 0.01 deg counts, nominal -120.00..130.00 C, bands to 155.00/-145.00.
// - Ni 100 Standard: 0.1 deg counts in C, F or K, nominal -60.0..250.0 C.
// - Ni 100 Climate: 0.01 deg counts, nominal -60.00..130.00 C, bands 155.00/-105.00.
// - Above overrange gives 7fff, below underrange gives 8000.
// - Wire break with its diagnostic enabled gives 7fff and a wire alarm, first priority.
// - Wire break, its diagnostic off, limit diagnostic on: 8000 and low-limit alarm.
// - Wire break with both diagnostics off: 8000 only, no alarm.
// - Each enabled diagnostic event makes a diagnostic record, and an interrupt if its bit is set in the mask register.
// - Result words are signed 16-bit two's complement.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps

module rtdenc_top (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Avalon-MM slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Linearised reading from the front end, 0.01 degC per count
	input wire logic sample_valid,
	input wire logic signed [23:0] sample_temp,
	// Wire break pin from the front end
	input wire logic wire_break,
	// Result toward the controller
	output logic [15:0] result_value,
	output rtdenc_pkg::rtdenc_band_e result_band,
	output logic result_valid,
	// Interrupt
	output logic irq
);

	// ==========================================
	// Scaling and limit decode
	function automatic logic signed [31:0] rnd10(input logic signed [31:0] x);
		logic signed [31:0] t;
		t = (x < 0) ? x - 32'sd5 : x + 32'sd5;
		return t / 32'sd10;
	endfunction : rnd10

	function automatic logic signed [31:0] scale(input rtdenc_pkg::rtdenc_ctrl_s c,
			input logic signed [31:0] t);
		logic signed [31:0] f;
		f = t * 32'sd9 / 32'sd5 + rtdenc_pkg::F_OFFSET;
		if (c.sensor == rtdenc_pkg::SENS_NI_STANDARD) begin
			case (c.unit)
				rtdenc_pkg::UNIT_FAHRENHEIT: return rnd10(f);
				rtdenc_pkg::UNIT_KELVIN: return rnd10(t + rtdenc_pkg::K_OFFSET);
				default: return rnd10(t);
			endcase
		end
		// Climate sensors have no Kelvin scale; Kelvin falls back to Celsius
		return (c.unit == rtdenc_pkg::UNIT_FAHRENHEIT) ? f : t;
	endfunction : scale

	function automatic rtdenc_pkg::rtdenc_lim_s limits(input rtdenc_pkg::rtdenc_ctrl_s c);
		logic fahr;
		fahr = (c.unit == rtdenc_pkg::UNIT_FAHRENHEIT);
		case (c.sensor)
			rtdenc_pkg::SENS_NI_STANDARD: begin
				if (fahr) return rtdenc_pkg::LIM_NS_F;
				if (c.unit == rtdenc_pkg::UNIT_KELVIN) return rtdenc_pkg::LIM_NS_K;
				return rtdenc_pkg::LIM_NS_C;
			end
			rtdenc_pkg::SENS_NI_CLIMATE: return fahr ? rtdenc_pkg::LIM_NC_F : rtdenc_pkg::LIM_NC_C;
			default: return fahr ? rtdenc_pkg::LIM_PT_F : rtdenc_pkg::LIM_PT_C;
		endcase
	endfunction : limits

	// ==========================================
	// Wire break synchroniser
	logic wb_meta;
	logic wb_sync;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wb_meta <= 1'b0;
			wb_sync <= 1'b0;
		end else begin
			wb_meta <= wire_break;
			wb_sync <= wb_meta;
		end
	end

	// ==========================================
	// State
	rtdenc_pkg::rtdenc_ctrl_s ctrl;
	logic [2:0] status;
	logic [2:0] mask;
	logic [2:0] last_event;
	logic [7:0] diag_count;

	rtdenc_pkg::rtdenc_ctrl_s next_ctrl;
	logic [2:0] next_status;
	logic [2:0] next_mask;
	logic [2:0] next_last_event;
	logic [7:0] next_diag_count;
	logic [15:0] next_result_value;
	rtdenc_pkg::rtdenc_band_e next_result_band;
	logic next_result_valid;
	logic next_irq;
	logic [31:0] next_readdata;
	logic next_waitrequest;

	logic signed [31:0] scaled;
	rtdenc_pkg::rtdenc_lim_s lim;
	rtdenc_pkg::rtdenc_band_e band;
	logic [2:0] events;
	logic wr_go;
	logic [2:0] w1c;

	// ==========================================
	// Classification and diagnostics
	always_comb begin
		scaled = scale(ctrl, 32'(sample_temp));
		lim = limits(ctrl);
		if (scaled > lim.over_hi) begin
			band = rtdenc_pkg::BAND_OVERFLOW;
		end else if (scaled > lim.nom_hi) begin
			band = rtdenc_pkg::BAND_OVERRANGE;
		end else if (scaled >= lim.nom_lo) begin
			band = rtdenc_pkg::BAND_NOMINAL;
		end else if (scaled >= lim.under_lo) begin
			band = rtdenc_pkg::BAND_UNDERRANGE;
		end else begin
			band = rtdenc_pkg::BAND_UNDERFLOW;
		end
		events = 3'h0;
		next_result_band = result_band;
		next_result_value = result_value;
		next_result_valid = sample_valid;
		if (sample_valid) begin
			next_result_band = band;
			if (wb_sync) begin
				// Wire break outranks the limit check; with its diagnostic off it raises the low-limit alarm if ovf_en is set
				if (ctrl.wb_en) begin
					next_result_value = rtdenc_pkg::CODE_OVERFLOW;
					events[rtdenc_pkg::EV_WIRE_BIT] = 1'b1;
				end else begin
					next_result_value = rtdenc_pkg::CODE_UNDERFLOW;
					events[rtdenc_pkg::EV_LOW_BIT] = ctrl.ovf_en;
				end
			end else if (band == rtdenc_pkg::BAND_OVERFLOW) begin
				next_result_value = rtdenc_pkg::CODE_OVERFLOW;
				events[rtdenc_pkg::EV_HIGH_BIT] = ctrl.ovf_en;
			end else if (band == rtdenc_pkg::BAND_UNDERFLOW) begin
				next_result_value = rtdenc_pkg::CODE_UNDERFLOW;
				events[rtdenc_pkg::EV_LOW_BIT] = ctrl.ovf_en;
			end else begin
				next_result_value = scaled[15:0];
			end
		end
	end

	// ==========================================
	// Register bus and interrupt
	always_comb begin
		wr_go = avs_write && !avs_waitrequest && avs_byteenable[0];
		next_ctrl = ctrl;
		next_mask = mask;
		w1c = 3'h0;
		if (wr_go) begin
			case (avs_address)
				rtdenc_pkg::ADDR_CTRL: next_ctrl = rtdenc_pkg::rtdenc_ctrl_s'(avs_writedata[5:0]);
				rtdenc_pkg::ADDR_STATUS: w1c = avs_writedata[2:0];
				rtdenc_pkg::ADDR_MASK: next_mask = avs_writedata[2:0];
				default: ;
			endcase
		end
		// A new event beats a clear in the same cycle
		next_status = (status & ~w1c) | events;
		next_last_event = last_event;
		next_diag_count = diag_count;
		if (events != 3'h0) begin
			next_last_event = events;
			next_diag_count = diag_count + 8'h01;
		end
		next_irq = |(status & mask);
		// One wait cycle, then the answer; read data sampled at the request's first edge
		next_waitrequest = !((avs_read || avs_write) && avs_waitrequest);
		next_readdata = avs_readdata;
		if (avs_read && avs_waitrequest) begin
			case (avs_address)
				rtdenc_pkg::ADDR_CTRL: next_readdata = {26'h0, ctrl};
				rtdenc_pkg::ADDR_STATUS: next_readdata = {29'h0, status};
				rtdenc_pkg::ADDR_MASK: next_readdata = {29'h0, mask};
				rtdenc_pkg::ADDR_RESULT: next_readdata = {13'h0, result_band, result_value};
				rtdenc_pkg::ADDR_DIAG: next_readdata = {16'h0, diag_count, 5'h0, last_event};
				default: next_readdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl <= rtdenc_pkg::CTRL_RESET;
			status <= rtdenc_pkg::EV_RESET;
			mask <= rtdenc_pkg::EV_RESET;
			last_event <= rtdenc_pkg::EV_RESET;
			diag_count <= rtdenc_pkg::COUNT_RESET;
			result_value <= 16'h0000;
			result_band <= rtdenc_pkg::BAND_NOMINAL;
			result_valid <= 1'b0;
			irq <= 1'b0;
			avs_readdata <= 32'h0;
			avs_waitrequest <= 1'b1;
		end else begin
			ctrl <= next_ctrl;
			status <= next_status;
			mask <= next_mask;
			last_event <= next_last_event;
			diag_count <= next_diag_count;
			result_value <= next_result_value;
			result_band <= next_result_band;
			result_valid <= next_result_valid;
			irq <= next_irq;
			avs_readdata <= next_readdata;
			avs_waitrequest <= next_waitrequest;
		end
	end

	// ==========================================
	// Assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	logic pt_c;
	logic nc_c;
	logic ns_c;
	assign pt_c = ctrl.sensor == rtdenc_pkg::SENS_PT_CLIMATE && ctrl.unit == rtdenc_pkg::UNIT_CELSIUS;
	assign nc_c = ctrl.sensor == rtdenc_pkg::SENS_NI_CLIMATE && ctrl.unit == rtdenc_pkg::UNIT_CELSIUS;
	assign ns_c = ctrl.sensor == rtdenc_pkg::SENS_NI_STANDARD && ctrl.unit == rtdenc_pkg::UNIT_CELSIUS;

	a_pt_nominal_pass: assert property (
		sample_valid && !wb_sync && pt_c && sample_temp >= -24'sd12000 && sample_temp <= 24'sd13000
		|=> result_band == rtdenc_pkg::BAND_NOMINAL && result_value == $past(sample_temp[15:0]))
		else $error("Pt climate nominal value not passed through");

	a_ns_band_edges: assert property (
		sample_valid && !wb_sync && ns_c && (sample_temp == 24'sd25005 || sample_temp == -24'sd6005)
		|=> result_band != rtdenc_pkg::BAND_NOMINAL && result_valid)
		else $error("Ni standard just past nominal edge classed nominal");

	a_nc_under_value: assert property (
		sample_valid && !wb_sync && nc_c && sample_temp >= -24'sd10500 && sample_temp < -24'sd6000
		|=> result_band == rtdenc_pkg::BAND_UNDERRANGE && $signed(result_value) < -16'sd6000)
		else $error("Ni climate underrange wrong");

	a_overflow_code: assert property (
		sample_valid && !wb_sync && scaled > lim.over_hi
		|=> result_value == rtdenc_pkg::CODE_OVERFLOW ##1 result_value == $past(result_value) || result_valid)
		else $error("Overflow code missing");

	a_underflow_code: assert property (
		sample_valid && !wb_sync && scaled < lim.under_lo |=> result_value == rtdenc_pkg::CODE_UNDERFLOW)
		else $error("Underflow code missing");

	a_wire_alarm: assert property (
		sample_valid && wb_sync && ctrl.wb_en
		|=> result_value == rtdenc_pkg::CODE_OVERFLOW && status[rtdenc_pkg::EV_WIRE_BIT]
		&& !$rose(status[rtdenc_pkg::EV_LOW_BIT]))
		else $error("Wire break with diagnostic not reported");

	a_wire_low_limit: assert property (
		sample_valid && wb_sync && !ctrl.wb_en && ctrl.ovf_en
		|=> result_value == rtdenc_pkg::CODE_UNDERFLOW && status[rtdenc_pkg::EV_LOW_BIT])
		else $error("Wire break did not raise low limit");

	a_wire_silent: assert property (
		sample_valid && wb_sync && !ctrl.wb_en && !ctrl.ovf_en
		|=> result_value == rtdenc_pkg::CODE_UNDERFLOW && (status & ~$past(status)) == 3'h0
		&& diag_count == $past(diag_count))
		else $error("Silent wire break raised an alarm");

	a_diag_irq: assert property (
		events != 3'h0 && (events & mask) != 3'h0 && !wr_go
		|=> diag_count == $past(diag_count) + 8'h01 ##1 irq)
		else $error("Diagnostic event without record or interrupt");

	// Wire break substitutes a code whatever the band, so only clean samples are held to this
	a_result_signed: assert property (
		result_valid && result_band == rtdenc_pkg::BAND_NOMINAL && !$past(wb_sync)
		|-> result_value != rtdenc_pkg::CODE_OVERFLOW && result_value != rtdenc_pkg::CODE_UNDERFLOW)
		else $error("Nominal value carries a limit code");

	a_band_inclusive: assert property (
		sample_valid && pt_c && (sample_temp == 24'sd13000 || sample_temp == -24'sd12000)
		|=> result_band == rtdenc_pkg::BAND_NOMINAL)
		else $error("Nominal limit not inclusive");

	c_wire_break: cover property (sample_valid && wb_sync && ctrl.wb_en ##[1:3] irq);
	c_overrange: cover property (result_valid && result_band == rtdenc_pkg::BAND_OVERRANGE);
	c_underflow: cover property (result_valid && result_band == rtdenc_pkg::BAND_UNDERFLOW);
	c_ns_kelvin: cover property (result_valid && ctrl.unit == rtdenc_pkg::UNIT_KELVIN);

endmodule : rtdenc_top

// ==== tb/rtdenc_frontend.sv ====
// Front end model: linearised temperature samples and the wire break pin
`timescale 1ns/10ps

module rtdenc_frontend (
	// Clock
	input wire logic sys_clk,
	// Toward the encoder
	output logic sample_valid,
	output logic signed [23:0] sample_temp,
	output logic wire_break
);
	// ==========================================
	// Idle levels
	initial begin
		sample_valid = 1'b0;
		sample_temp = 24'h5a5a5a;
		wire_break = 1'b0;
	end

	// ==========================================
	// Stimulus tasks
	// After a sample the value lines carry its inverse, so a stale capture shows up
	task send(input logic signed [23:0] t);
		@(posedge sys_clk);
		sample_valid <= 1'b1;
		sample_temp <= t;
		@(posedge sys_clk);
		sample_valid <= 1'b0;
		sample_temp <= ~t;
	endtask : send

	task set_break(input logic b);
		@(posedge sys_clk);
		wire_break <= b;
	endtask : set_break
endmodule : rtdenc_frontend

// ==== tb/test_rtd_value_range_encoder.sv ====
// Testbench of the thermometer value range encoder
`timescale 1ns/10ps

module test_rtd_value_range_encoder;
	// ==========================================
	// Signals
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic sample_valid;
	logic signed [23:0] sample_temp;
	logic wire_break;
	logic [15:0] result_value;
	rtdenc_pkg::rtdenc_band_e result_band;
	logic result_valid;
	logic irq;
	logic [31:0] rd;
	int fails = 0;
	int tests_run = 0;

	always #2.5 sys_clk = ~sys_clk;

	rtdenc_top i_rtdenc_top (.sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.sample_valid(sample_valid), .sample_temp(sample_temp), .wire_break(wire_break),
		.result_value(result_value), .result_band(result_band), .result_valid(result_valid), .irq(irq));

	rtdenc_frontend i_rtdenc_frontend (.sys_clk(sys_clk), .sample_valid(sample_valid),
		.sample_temp(sample_temp), .wire_break(wire_break));

	// ==========================================
	// Tasks
	task check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// Request held until waitrequest is seen low at a rising edge
	// No answer time is assumed; only the watchdog ends a hung wait
	task bus(input logic wr, input logic [4:0] addr, input logic [31:0] data);
		@(posedge sys_clk);
		avs_address <= addr;
		avs_writedata <= data;
		avs_write <= wr;
		avs_read <= ~wr;
		do begin
			@(posedge sys_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus

	task rdck(input logic [4:0] addr, input logic [31:0] exp);
		bus(1'b0, addr, 32'h0);
		check(rd, exp);
	endtask : rdck

	task sample(input logic [5:0] ctrl, input int t, input logic [15:0] ev, input rtdenc_pkg::rtdenc_band_e eb);
		bus(1'b1, rtdenc_pkg::ADDR_CTRL, {26'h0, ctrl});
		i_rtdenc_frontend.send(t[23:0]);
		#1;
		check({31'h0, result_valid}, 32'h1);
		check({16'h0, result_value}, {16'h0, ev});
		check({29'h0, result_band}, {29'h0, eb});
	endtask : sample

	task irqck(input logic exp);
		repeat (3) @(posedge sys_clk);
		#1;
		check({31'h0, irq}, {31'h0, exp});
	endtask : irqck

	task stop_test;
		$display("tests_run %0d fails %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test

	// ==========================================
	// Reset, watchdog and tests
	initial begin
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
	end

	// Whole run is a few hundred cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		stop_test;
	end

	initial begin
		@(posedge resetn);
		rdck(rtdenc_pkg::ADDR_STATUS, 32'h0);
		rdck(5'h14, 32'h0);
		sample(6'h00, 13000, 16'h32c8, rtdenc_pkg::BAND_NOMINAL);
		sample(6'h00, 13001, 16'h32c9, rtdenc_pkg::BAND_OVERRANGE);
		sample(6'h00, 15500, 16'h3c8c, rtdenc_pkg::BAND_OVERRANGE);
		sample(6'h00, 15501, 16'h7fff, rtdenc_pkg::BAND_OVERFLOW);
		sample(6'h00, -12000, 16'hd120, rtdenc_pkg::BAND_NOMINAL);
		sample(6'h00, -12001, 16'hd11f, rtdenc_pkg::BAND_UNDERRANGE);
		sample(6'h00, -14500, 16'hc75c, rtdenc_pkg::BAND_UNDERRANGE);
		sample(6'h00, -14501, 16'h8000, rtdenc_pkg::BAND_UNDERFLOW);
		sample(6'h04, 15500, 16'h797c, rtdenc_pkg::BAND_OVERRANGE);
		sample(6'h04, 15501, 16'h7fff, rtdenc_pkg::BAND_OVERFLOW);
		sample(6'h04, -12001, 16'hb81f, rtdenc_pkg::BAND_UNDERRANGE);
		sample(6'h01, 25000, 16'h09c4, rtdenc_pkg::BAND_NOMINAL);
		sample(6'h01, 25005, 16'h09c5, rtdenc_pkg::BAND_OVERRANGE);
		sample(6'h01, -6005, 16'hfda7, rtdenc_pkg::BAND_UNDERRANGE);
		sample(6'h01, -10506, 16'h8000, rtdenc_pkg::BAND_UNDERFLOW);
		sample(6'h05, 25000, 16'h12d4, rtdenc_pkg::BAND_NOMINAL);
		sample(6'h09, 0, 16'h0aac, rtdenc_pkg::BAND_NOMINAL);
		sample(6'h09, 29505, 16'h1632, rtdenc_pkg::BAND_OVERRANGE);
		sample(6'h02, -6001, 16'he88f, rtdenc_pkg::BAND_UNDERRANGE);
		sample(6'h02, -10501, 16'h8000, rtdenc_pkg::BAND_UNDERFLOW);
		sample(6'h02, 15501, 16'h7fff, rtdenc_pkg::BAND_OVERFLOW);
		sample(6'h06, -7600, 16'hd710, rtdenc_pkg::BAND_UNDERRANGE);
		sample(6'h0a, -6001, 16'he88f, rtdenc_pkg::BAND_UNDERRANGE);
		sample(6'h03, 13001, 16'h32c9, rtdenc_pkg::BAND_OVERRANGE);
		rdck(rtdenc_pkg::ADDR_STATUS, 32'h0);
		sample(6'h20, 15501, 16'h7fff, rtdenc_pkg::BAND_OVERFLOW);
		rdck(rtdenc_pkg::ADDR_STATUS, 32'h4);
		i_rtdenc_frontend.set_break(1'b1);
		repeat (3) @(posedge sys_clk);
		bus(1'b1, rtdenc_pkg::ADDR_STATUS, 32'h7);
		sample(6'h10, 0, 16'h7fff, rtdenc_pkg::BAND_NOMINAL);
		rdck(rtdenc_pkg::ADDR_STATUS, 32'h1);
		bus(1'b0, rtdenc_pkg::ADDR_DIAG, 32'h0);
		check(rd, 32'h0000_0201);
		bus(1'b1, rtdenc_pkg::ADDR_STATUS, 32'h7);
		sample(6'h30, 0, 16'h7fff, rtdenc_pkg::BAND_NOMINAL);
		rdck(rtdenc_pkg::ADDR_STATUS, 32'h1);
		bus(1'b1, rtdenc_pkg::ADDR_STATUS, 32'h7);
		sample(6'h00, 0, 16'h8000, rtdenc_pkg::BAND_NOMINAL);
		rdck(rtdenc_pkg::ADDR_STATUS, 32'h0);
		sample(6'h20, 0, 16'h8000, rtdenc_pkg::BAND_NOMINAL);
		rdck(rtdenc_pkg::ADDR_STATUS, 32'h2);
		rdck(rtdenc_pkg::ADDR_RESULT, 32'h0000_8000);
		bus(1'b1, rtdenc_pkg::ADDR_MASK, 32'h1);
		irqck(1'b0);
		bus(1'b1, rtdenc_pkg::ADDR_MASK, 32'h2);
		irqck(1'b1);
		bus(1'b1, rtdenc_pkg::ADDR_STATUS, 32'h2);
		irqck(1'b0);
		sample(6'h20, 0, 16'h8000, rtdenc_pkg::BAND_NOMINAL);
		irqck(1'b1);
		rdck(rtdenc_pkg::ADDR_CTRL, 32'h20);
		@(posedge sys_clk);
		avs_byteenable <= 4'h0;
		bus(1'b1, rtdenc_pkg::ADDR_MASK, 32'h5);
		avs_byteenable <= 4'hf;
		rdck(rtdenc_pkg::ADDR_MASK, 32'h2);
		i_rtdenc_frontend.set_break(1'b0);
		stop_test;
	end
endmodule : test_rtd_value_range_encoder
